// ---- shared/fpdec_defines.vh ----
// Opcode, function code and decoder encoding constants
`ifndef FPDEC_DEFINES_VH
`define FPDEC_DEFINES_VH
// Primary opcodes
`define OPC_PAL_CALL   6'h00
`define OPC_MISC       6'h18
`define OPC_INT_ARITH  6'h10
`define OPC_INT_LOGIC  6'h11
`define OPC_INT_SHIFT  6'h12
`define OPC_INT_MUL    6'h13
`define OPC_MAKER_RES  6'h14
`define OPC_VAX_FLOAT  6'h15
`define OPC_IEEE_FLOAT 6'h16
`define OPC_FLT_OPER   6'h17
`define OPC_HW_MFPR    6'h19
`define OPC_JUMP       6'h1a
`define OPC_HW_LD      6'h1b
`define OPC_SEXT_MVI   6'h1c
`define OPC_HW_MTPR    6'h1d
`define OPC_HW_RET     6'h1e
`define OPC_HW_ST      6'h1f
// Instruction groups
`define GRP_W          4'h4
`define GRP_PAL_CALL   4'h0
`define GRP_MEM        4'h1
`define GRP_BRANCH     4'h2
`define GRP_INT_ARITH  4'h3
`define GRP_INT_LOGIC  4'h4
`define GRP_INT_SHIFT  4'h5
`define GRP_INT_MUL    4'h6
`define GRP_VAX_FLOAT  4'h7
`define GRP_IEEE_FLOAT 4'h8
`define GRP_FLT_OPER   4'h9
`define GRP_MISC       4'ha
`define GRP_JUMP       4'hb
`define GRP_SEXT_MVI   4'hc
`define GRP_PAL_HW     4'hd
`define GRP_RES_MAKER  4'he
// Privileged hardware sub-operations
`define PHW_NONE       3'h0
`define PHW_LOAD       3'h1
`define PHW_STORE      3'h2
`define PHW_RETURN     3'h3
`define PHW_MFPR       3'h4
`define PHW_MTPR       3'h5
// Floating operations
`define FOP_NONE       5'h00
`define FOP_ADD_S      5'h01
`define FOP_SUB_S      5'h02
`define FOP_MUL_S      5'h03
`define FOP_DIV_S      5'h04
`define FOP_ADD_D      5'h05
`define FOP_SUB_D      5'h06
`define FOP_MUL_D      5'h07
`define FOP_DIV_D      5'h08
`define FOP_CMP_UN     5'h09
`define FOP_CMP_EQ     5'h0a
`define FOP_CMP_LT     5'h0b
`define FOP_CMP_LE     5'h0c
`define FOP_Q_TO_S     5'h0d
`define FOP_Q_TO_D     5'h0e
`define FOP_D_TO_S     5'h0f
`define FOP_S_TO_D     5'h10
`define FOP_D_TO_Q     5'h11
`define FOP_VD_TO_G    5'h12
`define FOP_VG_TO_D    5'h13
// Rounding modes
`define RND_NORMAL     2'h0
`define RND_CHOPPED    2'h1
`define RND_MINUS_INF  2'h2
`define RND_DYNAMIC    2'h3
// Qualifier bits of the function code
`define FC_SW_BIT      10
`define FC_INEXACT_BIT 9
`define FC_TRAP_BIT    8
`define FC_RND_HI      7
`define FC_RND_LO      6
// Decode latency in cycles from valid in to valid out
`define DEC_LATENCY    1
`endif

// ---- hw/opcode_group_decode.v ----
// Primary opcode to instruction group decode
`timescale 1ns/1ps
`include "fpdec_defines.vh"
module opcode_group_decode (
    input  wire [5:0] opcode,
    output reg  [3:0] group,
    output reg  [2:0] pal_hw_op,
    output reg        reserved
);
    always @* begin
        group     = `GRP_RES_MAKER;
        pal_hw_op = `PHW_NONE;
        reserved  = 1'b0;
        if (opcode[5:4] == 2'b11) begin
            group = `GRP_BRANCH;
        end else if (opcode[5:4] == 2'b10 || opcode[5:3] == 3'b001) begin
            group = `GRP_MEM;
        end else begin
            case (opcode)
                `OPC_PAL_CALL:   group = `GRP_PAL_CALL;
                `OPC_INT_ARITH:  group = `GRP_INT_ARITH;
                `OPC_INT_LOGIC:  group = `GRP_INT_LOGIC;
                `OPC_INT_SHIFT:  group = `GRP_INT_SHIFT;
                `OPC_INT_MUL:    group = `GRP_INT_MUL;
                `OPC_JUMP:       group = `GRP_JUMP;
                `OPC_IEEE_FLOAT: group = `GRP_IEEE_FLOAT;
                `OPC_VAX_FLOAT:  group = `GRP_VAX_FLOAT;
                `OPC_FLT_OPER:   group = `GRP_FLT_OPER;
                `OPC_MISC:       group = `GRP_MISC;
                `OPC_SEXT_MVI:   group = `GRP_SEXT_MVI;
                `OPC_HW_LD: begin
                    group     = `GRP_PAL_HW;
                    pal_hw_op = `PHW_LOAD;
                end
                `OPC_HW_ST: begin
                    group     = `GRP_PAL_HW;
                    pal_hw_op = `PHW_STORE;
                end
                `OPC_HW_RET: begin
                    group     = `GRP_PAL_HW;
                    pal_hw_op = `PHW_RETURN;
                end
                `OPC_HW_MFPR: begin
                    group     = `GRP_PAL_HW;
                    pal_hw_op = `PHW_MFPR;
                end
                `OPC_HW_MTPR: begin
                    group     = `GRP_PAL_HW;
                    pal_hw_op = `PHW_MTPR;
                end
                // 01..07 and 14 reserved to maker
                default: begin
                    group    = `GRP_RES_MAKER;
                    reserved = 1'b1;
                end
            endcase
        end
    end
endmodule

// ---- hw/fp_code_table.v ----
// Floating-point function code tables for IEEE and VAX groups
`timescale 1ns/1ps
`include "fpdec_defines.vh"
module fp_code_table (
    input  wire        is_vax,
    input  wire [10:0] func,
    output reg  [4:0]  fop,
    output reg         legal
);
    reg [1:0] rnd;
    reg [2:0] trap;
    reg [4:0] base;
    always @* begin
        rnd   = func[`FC_RND_HI:`FC_RND_LO];
        trap  = {func[`FC_SW_BIT], func[`FC_INEXACT_BIT], func[`FC_TRAP_BIT]};
        fop   = `FOP_NONE;
        legal = 1'b0;
        base  = `FOP_NONE;
        // Low six bits name the operation
        case (func[5:0])
            6'h00: base = `FOP_ADD_S;
            6'h01: base = `FOP_SUB_S;
            6'h02: base = `FOP_MUL_S;
            6'h03: base = `FOP_DIV_S;
            6'h20: base = `FOP_ADD_D;
            6'h21: base = `FOP_SUB_D;
            6'h22: base = `FOP_MUL_D;
            6'h23: base = `FOP_DIV_D;
            6'h24: base = is_vax ? `FOP_NONE : `FOP_CMP_UN;
            6'h25: base = `FOP_CMP_EQ;
            6'h26: base = `FOP_CMP_LT;
            6'h27: base = `FOP_CMP_LE;
            6'h3c: base = `FOP_Q_TO_S;
            6'h3e: base = `FOP_Q_TO_D;
            // Single-to-double owns 2AC/6AC only: bits 9:6 read 1010
            6'h2c: base = (!is_vax && func[9:6] == 4'b1010) ? `FOP_S_TO_D : `FOP_D_TO_S;
            6'h2f: base = `FOP_D_TO_Q;
            6'h1e: base = is_vax ? `FOP_VD_TO_G : `FOP_NONE;
            6'h2d: base = is_vax ? `FOP_VG_TO_D : `FOP_NONE;
            default: base = `FOP_NONE;
        endcase
        fop = base;
        if (!is_vax) begin
            case (base)
                `FOP_ADD_S, `FOP_SUB_S, `FOP_MUL_S, `FOP_DIV_S,
                `FOP_ADD_D, `FOP_SUB_D, `FOP_MUL_D, `FOP_DIV_D,
                `FOP_D_TO_S:
                    legal = (trap == 3'b000) || (trap == 3'b001) ||
                            (trap == 3'b101) || (trap == 3'b111);
                `FOP_CMP_UN, `FOP_CMP_EQ, `FOP_CMP_LT, `FOP_CMP_LE:
                    legal = (rnd == 2'b10) && ((trap == 3'b000) || (trap == 3'b101));
                `FOP_Q_TO_S, `FOP_Q_TO_D:
                    legal = (trap == 3'b000) || (trap == 3'b111);
                `FOP_S_TO_D:
                    legal = (trap == 3'b010) || (trap == 3'b110);
                `FOP_D_TO_Q:
                    legal = (trap == 3'b000) || (trap == 3'b001) ||
                            (trap == 3'b101) || (trap == 3'b111);
                default: legal = 1'b0;
            endcase
        end else begin
            // VAX has only normal and chopped rounding, no inexact bit
            case (base)
                `FOP_ADD_S, `FOP_SUB_S, `FOP_MUL_S, `FOP_DIV_S,
                `FOP_ADD_D, `FOP_SUB_D, `FOP_MUL_D, `FOP_DIV_D,
                `FOP_D_TO_S, `FOP_VD_TO_G, `FOP_VG_TO_D:
                    legal = !func[`FC_RND_LO] && !func[`FC_INEXACT_BIT];
                `FOP_CMP_EQ, `FOP_CMP_LT, `FOP_CMP_LE:
                    legal = (rnd == 2'b10) && !func[`FC_INEXACT_BIT] &&
                            !func[`FC_TRAP_BIT];
                `FOP_Q_TO_S, `FOP_Q_TO_D:
                    legal = !func[`FC_RND_LO] && (trap == 3'b000);
                `FOP_D_TO_Q:
                    legal = !func[`FC_RND_LO] && !func[`FC_INEXACT_BIT];
                default: legal = 1'b0;
            endcase
        end
        if (!legal) begin
            fop = `FOP_NONE;
        end
    end
endmodule

// ---- hw/fp_function_code_decoder.v ----
// Instruction group and floating function code decoder, registered outputs
//
// How it works
// - Opcode 16 is the IEEE float group, decoded by 11-bit function.
// - Opcode 15 is the VAX float group, same field, separate table.
// - IEEE single arithmetic at 080-083, double at 0A0-0A3.
// - Rounding from bits: normal, chopped, minus infinity, dynamic.
// - Added 100 enables underflow trap, e.g. 182.
// - Added 500 software underflow, 700 software underflow inexact.
// - Double compares only 0A4-0A7 or 5A4-5A7.
// - Quad-to-float conversions at 0BC/0BE, no underflow-only forms.
// - Single-to-double only 2AC or 6AC; double-to-single fully qualified.
// - IEEE double-to-quad at 0AF with overflow and software variants.
// - VAX arithmetic: chopped, underflow 100, software 400.
// - VAX double-to-quad at 0AF with chopped, overflow, software.
// - All 64 primary opcodes 00 through 3F decoded.
// - 12 shift, 1A jump, 10/11/13 arithmetic, logical, multiply.
// - 19,1B,1D,1E,1F privileged hardware; 01-07 and 14 maker reserved.
// - 08-0F, 20-2F memory format; 30-3F branch format.
// - 1C sign-extend/motion-video, 18 miscellaneous memory group.
// - Privileged hardware load, store, return, move-from, move-to.
`timescale 1ns/1ps
`include "fpdec_defines.vh"
module fp_function_code_decoder (
    input  wire        CLK_SYS,
    input  wire        RST,
    input  wire        INSN_VALID,
    input  wire [31:0] INSN,
    output reg         DEC_VALID,
    output reg  [3:0]  GROUP,
    output reg  [2:0]  PAL_HW_OP,
    output reg  [4:0]  FP_OP,
    output reg  [1:0]  ROUND_MODE,
    output reg         ROUND_DYNAMIC,
    output reg         TRAP_UNDERFLOW,
    output reg         TRAP_OVERFLOW,
    output reg         TRAP_INEXACT,
    output reg         SW_COMPLETION,
    output reg         ILLEGAL
);
    // ------------------------------------------------------------
    // Field split
    // ------------------------------------------------------------
    wire [5:0]  opcode = INSN[31:26];
    wire [10:0] func   = INSN[15:5];
    wire [3:0]  group;
    wire [2:0]  pal_hw_op;
    wire        reserved;
    wire [4:0]  fop;
    wire        fp_legal;
    wire        is_fp  = (group == `GRP_IEEE_FLOAT) || (group == `GRP_VAX_FLOAT);
    wire        is_vax = (group == `GRP_VAX_FLOAT);

    opcode_group_decode u_group (
        .opcode    (opcode),
        .group     (group),
        .pal_hw_op (pal_hw_op),
        .reserved  (reserved)
    );

    fp_code_table u_table (
        .is_vax (is_vax),
        .func   (func),
        .fop    (fop),
        .legal  (fp_legal)
    );

    // ------------------------------------------------------------
    // Qualifier extraction
    // ------------------------------------------------------------
    reg [1:0] next_round;
    reg       next_unf;
    reg       next_ovf;
    reg       next_ine;
    reg       next_sw;
    reg       next_illegal;
    reg       to_quad;
    always @* begin
        next_round   = `RND_NORMAL;
        next_unf     = 1'b0;
        next_ovf     = 1'b0;
        next_ine     = 1'b0;
        next_sw      = 1'b0;
        to_quad      = (fop == `FOP_D_TO_Q);
        next_illegal = reserved || (is_fp && !fp_legal);
        if (is_fp && fp_legal) begin
            case (func[`FC_RND_HI:`FC_RND_LO])
                2'b10:   next_round = `RND_NORMAL;
                2'b00:   next_round = `RND_CHOPPED;
                2'b01:   next_round = `RND_MINUS_INF;
                2'b11:   next_round = `RND_DYNAMIC;
                default: next_round = `RND_NORMAL;
            endcase
            // Single-to-double carries rounding bits as part of its code
            if (fop == `FOP_S_TO_D) begin
                next_round = `RND_NORMAL;
            end
            // trap bit is underflow, or overflow for quad results
            next_unf = func[`FC_TRAP_BIT] && !to_quad;
            next_ovf = func[`FC_TRAP_BIT] && to_quad;
            next_sw  = func[`FC_SW_BIT];
            next_ine = func[`FC_INEXACT_BIT] && !is_vax;
            // Bit 9 of the single-to-double code is part of the code, not inexact
            if (fop == `FOP_S_TO_D) begin
                next_ine = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            DEC_VALID      <= 1'b0;
            GROUP          <= `GRP_PAL_CALL;
            PAL_HW_OP      <= `PHW_NONE;
            FP_OP          <= `FOP_NONE;
            ROUND_MODE     <= `RND_NORMAL;
            ROUND_DYNAMIC  <= 1'b0;
            TRAP_UNDERFLOW <= 1'b0;
            TRAP_OVERFLOW  <= 1'b0;
            TRAP_INEXACT   <= 1'b0;
            SW_COMPLETION  <= 1'b0;
            ILLEGAL        <= 1'b0;
        end else begin
            DEC_VALID <= INSN_VALID;
            // Hold fields while idle so downstream sees stable values
            if (INSN_VALID) begin
                GROUP          <= group;
                PAL_HW_OP      <= pal_hw_op;
                FP_OP          <= is_fp ? fop : `FOP_NONE;
                ROUND_MODE     <= next_round;
                ROUND_DYNAMIC  <= (next_round == `RND_DYNAMIC);
                TRAP_UNDERFLOW <= next_unf;
                TRAP_OVERFLOW  <= next_ovf;
                TRAP_INEXACT   <= next_ine;
                SW_COMPLETION  <= next_sw;
                ILLEGAL        <= next_illegal;
            end
        end
    end
endmodule

// ---- tb/fp_decode_monitor.sv ----
// Port-level checker for the opcode and function code decoder
`timescale 1ns/1ps
`include "fpdec_defines.vh"
module fp_decode_monitor (
    input wire        CLK_SYS,
    input wire        RST,
    input wire        INSN_VALID,
    input wire [31:0] INSN,
    input wire        DEC_VALID,
    input wire [3:0]  GROUP,
    input wire [2:0]  PAL_HW_OP,
    input wire [4:0]  FP_OP,
    input wire [1:0]  ROUND_MODE,
    input wire        ROUND_DYNAMIC,
    input wire        TRAP_UNDERFLOW,
    input wire        TRAP_OVERFLOW,
    input wire        TRAP_INEXACT,
    input wire        SW_COMPLETION,
    input wire        ILLEGAL
);
    wire [5:0]  op = INSN[31:26];
    wire [10:0] fc = INSN[15:5];
    wire        take = INSN_VALID;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    valid_latency_a:
        assert property (take |=> DEC_VALID) else $error("decode result late or missing");
    idle_hold_a:
        assert property (!take |=> !DEC_VALID && $stable(GROUP) && $stable(FP_OP))
        else $error("result changed without a request");
    ieee_group_a:
        assert property (take && op == 6'h16 |=> GROUP == `GRP_IEEE_FLOAT)
        else $error("ieee float opcode misgrouped");
    vax_group_a:
        assert property (take && op == 6'h15 |=> GROUP == `GRP_VAX_FLOAT)
        else $error("vax float opcode misgrouped");
    maker_reserved_a:
        assert property (take && (op inside {[6'h01:6'h07], 6'h14}) |=> ILLEGAL && GROUP == 4'he)
        else $error("reserved opcode not flagged");
    hw_load_a:
        assert property (take && op == 6'h1b |=> PAL_HW_OP == `PHW_LOAD && !ILLEGAL)
        else $error("privileged load not recognised");
    branch_group_a:
        assert property (take && op[5:4] == 2'h3 |=> GROUP == `GRP_BRANCH)
        else $error("branch opcode misgrouped");
    dynamic_flag_a:
        assert property (DEC_VALID |-> ROUND_DYNAMIC == (ROUND_MODE == `RND_DYNAMIC))
        else $error("dynamic flag disagrees with mode");
    sw_underflow_a:
        assert property (take && op == 6'h16 && fc == 11'h580 |=> SW_COMPLETION && TRAP_UNDERFLOW)
        else $error("software underflow qualifier lost");
    cmp_qualified_a:
        assert property (take && op == 6'h16 && fc == 11'h1a5 |=> ILLEGAL && FP_OP == `FOP_NONE)
        else $error("underflow-only compare accepted");
    cvt_single_double_a:
        assert property (take && op == 6'h16 && fc == 11'h2ac |=>
            FP_OP == `FOP_S_TO_D && !ILLEGAL && !TRAP_INEXACT)
        else $error("single-to-double code misdecoded");
    nonfp_quiet_a:
        assert property (DEC_VALID && GROUP != 4'h7 && GROUP != 4'h8 |->
            FP_OP == 5'h00 && !TRAP_UNDERFLOW && !TRAP_INEXACT && !SW_COMPLETION)
        else $error("qualifiers set on non-float decode");
endmodule

// ---- tb/insn_issue_model.sv ----
// Issue stage model feeding one instruction word per cycle
`timescale 1ns/1ps
module insn_issue_model (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        req,
    input  wire [31:0] word,
    output reg         insn_valid,
    output reg  [31:0] insn
);
    // Idle cycles scramble the word so stale fields are never mistaken for held ones
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            insn_valid <= 1'b0;
            insn       <= 32'h0;
        end else begin
            insn_valid <= req;
            insn       <= req ? word : ~insn;
        end
    end
endmodule

// ---- tb/fp_function_code_decoder_tb_top.sv ----
// Self-checking testbench for the opcode and function code decoder
`timescale 1ns/1ps
`include "fpdec_defines.vh"
module fp_function_code_decoder_tb_top;
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg         req = 1'b0;
    reg  [31:0] word = 32'h0;
    reg  [31:0] lfsr = 32'h56dc;
    reg  [18:0] exp_q[$];
    integer     error_cnt = 0;
    integer     tests_run = 0;
    integer     i;
    wire        insn_valid, dec_valid, rnd_dyn, t_unf, t_ovf, t_inx, sw_c, ill;
    wire [31:0] insn;
    wire [3:0]  grp;
    wire [2:0]  phw;
    wire [4:0]  fop;
    wire [1:0]  rm;

    always #5 clk_sys = ~clk_sys;

    insn_issue_model i_issue (.clk_sys(clk_sys), .rst(rst), .req(req), .word(word),
        .insn_valid(insn_valid), .insn(insn));
    fp_function_code_decoder i_dut (.CLK_SYS(clk_sys), .RST(rst), .INSN_VALID(insn_valid),
        .INSN(insn), .DEC_VALID(dec_valid), .GROUP(grp), .PAL_HW_OP(phw), .FP_OP(fop),
        .ROUND_MODE(rm), .ROUND_DYNAMIC(rnd_dyn), .TRAP_UNDERFLOW(t_unf),
        .TRAP_OVERFLOW(t_ovf), .TRAP_INEXACT(t_inx), .SW_COMPLETION(sw_c), .ILLEGAL(ill));

    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Group and privileged sub-operation expected for a primary opcode
    function [6:0] grp_of(input [5:0] op);
        if (op >= 6'h30) grp_of = {4'h2, 3'h0};
        else if (op >= 6'h20 || (op >= 6'h08 && op <= 6'h0f)) grp_of = {4'h1, 3'h0};
        else if (op == 6'h00) grp_of = 7'h0;
        else if (op <= 6'h07 || op == 6'h14) grp_of = {4'he, 3'h0};
        else case (op)
            6'h10: grp_of = {4'h3, 3'h0};
            6'h11: grp_of = {4'h4, 3'h0};
            6'h12: grp_of = {4'h5, 3'h0};
            6'h13: grp_of = {4'h6, 3'h0};
            6'h15: grp_of = {4'h7, 3'h0};
            6'h16: grp_of = {4'h8, 3'h0};
            6'h17: grp_of = {4'h9, 3'h0};
            6'h18: grp_of = {4'ha, 3'h0};
            6'h19: grp_of = {4'hd, 3'h4};
            6'h1a: grp_of = {4'hb, 3'h0};
            6'h1b: grp_of = {4'hd, 3'h1};
            6'h1c: grp_of = {4'hc, 3'h0};
            6'h1d: grp_of = {4'hd, 3'h5};
            6'h1e: grp_of = {4'hd, 3'h3};
            default: grp_of = {4'hd, 3'h2};
        endcase
    endfunction

    task send(input [5:0] op, input [10:0] fc, input [18:0] e);
        begin
            @(posedge clk_sys);
            lfsr = lfsr_next(lfsr);
            req <= 1'b1;
            word <= {op, lfsr[9:0], fc, lfsr[14:10]};
            exp_q.push_back(e);
        end
    endtask

    // Float code: flags are {sw, inexact, overflow, underflow}; no op means illegal
    task fpi(input [5:0] op, input [10:0] fc, input [4:0] f, input [1:0] r, input [3:0] fl);
        begin
            send(op, fc, {(op == 6'h15) ? 4'h7 : 4'h8, 3'h0, f, r, fl, f == 5'h00});
        end
    endtask

    task check_dec(input [18:0] e);
        reg [18:0] got;
        begin
            got = {grp, phw, fop, rm, sw_c, t_inx, t_ovf, t_unf, ill};
            tests_run = tests_run + 1;
            if (got !== e || rnd_dyn !== (e[6:5] == 2'h3)) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED at %0t: decode got %h expected %h", $time, got, e);
            end
        end
    endtask

    task stop_test;
        begin
            if (error_cnt == 0 && tests_run > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(negedge clk_sys) begin
        if (!rst && dec_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED at %0t: result without request", $time);
            end else
                check_dec(exp_q.pop_front());
        end
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        for (i = 0; i < 64; i = i + 1)
            send(i[5:0], 11'h080, {grp_of(i[5:0]), (i == 21 || i == 22) ? 5'h01 : 5'h00,
                6'h0, grp_of(i[5:0]) >= 7'h70 && grp_of(i[5:0]) < 7'h78});
        @(posedge clk_sys) req <= 1'b0;
        fpi(6'h16, 11'h080, `FOP_ADD_S, 2'h0, 4'h0);
        fpi(6'h16, 11'h0a3, `FOP_DIV_D, 2'h0, 4'h0);
        fpi(6'h16, 11'h003, `FOP_DIV_S, 2'h1, 4'h0);
        fpi(6'h16, 11'h043, `FOP_DIV_S, 2'h2, 4'h0);
        fpi(6'h16, 11'h0c3, `FOP_DIV_S, 2'h3, 4'h0);
        fpi(6'h16, 11'h182, `FOP_MUL_S, 2'h0, 4'h1);
        fpi(6'h16, 11'h580, `FOP_ADD_S, 2'h0, 4'h9);
        fpi(6'h16, 11'h780, `FOP_ADD_S, 2'h0, 4'hd);
        fpi(6'h16, 11'h0a5, `FOP_CMP_EQ, 2'h0, 4'h0);
        fpi(6'h16, 11'h5a7, `FOP_CMP_LE, 2'h0, 4'h9);
        fpi(6'h16, 11'h1a5, 5'h00, 2'h0, 4'h0);
        fpi(6'h16, 11'h0bc, `FOP_Q_TO_S, 2'h0, 4'h0);
        fpi(6'h16, 11'h7be, `FOP_Q_TO_D, 2'h0, 4'hd);
        fpi(6'h16, 11'h1bc, 5'h00, 2'h0, 4'h0);
        fpi(6'h16, 11'h2ac, `FOP_S_TO_D, 2'h0, 4'h0);
        fpi(6'h16, 11'h6ac, `FOP_S_TO_D, 2'h0, 4'h8);
        fpi(6'h16, 11'h0ac, `FOP_D_TO_S, 2'h0, 4'h0);
        fpi(6'h16, 11'h22c, 5'h00, 2'h0, 4'h0);
        fpi(6'h16, 11'h1ec, `FOP_D_TO_S, 2'h3, 4'h1);
        fpi(6'h16, 11'h7af, `FOP_D_TO_Q, 2'h0, 4'he);
        fpi(6'h16, 11'h06f, `FOP_D_TO_Q, 2'h2, 4'h0);
        fpi(6'h15, 11'h5a3, `FOP_DIV_D, 2'h0, 4'h9);
        fpi(6'h15, 11'h423, `FOP_DIV_D, 2'h1, 4'h8);
        fpi(6'h15, 11'h7a3, 5'h00, 2'h0, 4'h0);
        fpi(6'h15, 11'h4af, `FOP_D_TO_Q, 2'h0, 4'h8);
        fpi(6'h15, 11'h12f, `FOP_D_TO_Q, 2'h1, 4'h2);
        fpi(6'h15, 11'h0a4, 5'h00, 2'h0, 4'h0);
        @(posedge clk_sys) req <= 1'b0;
        for (i = 0; i < 50 && exp_q.size() > 0; i = i + 1)
            @(posedge clk_sys);
        if (exp_q.size() > 0) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED at %0t: results missing", $time);
        end
        stop_test;
    end
endmodule

bind fp_function_code_decoder fp_decode_monitor i_mon (.CLK_SYS(CLK_SYS), .RST(RST),
    .INSN_VALID(INSN_VALID), .INSN(INSN), .DEC_VALID(DEC_VALID), .GROUP(GROUP),
    .PAL_HW_OP(PAL_HW_OP), .FP_OP(FP_OP), .ROUND_MODE(ROUND_MODE),
    .ROUND_DYNAMIC(ROUND_DYNAMIC), .TRAP_UNDERFLOW(TRAP_UNDERFLOW),
    .TRAP_OVERFLOW(TRAP_OVERFLOW), .TRAP_INEXACT(TRAP_INEXACT),
    .SW_COMPLETION(SW_COMPLETION), .ILLEGAL(ILLEGAL));
